// ===== inc/bdm_regs.vh
// Purpose: constants for banked data memory addressing
// Assumes: 12-bit byte addresses, 8-bit data, one core clock
// Notes: included by every design file of the block
//
// How it works
// - 12-bit byte address, 4096 static locations.
// - sixteen banks of 256 bytes, all present.
// - reads of empty locations give zero.
// - banked address: pointer high, offset low.
// - pointer keeps four bits, upper read zero.
// - load-bank-literal writes pointer from immediate.
// - unimplemented bank: drop writes, read zeros.
// - status flags update as if access succeeded.
// - full-address move uses two 12-bit addresses.
// - other instructions use pointer or access map.
// - access map: bank 0 low, bank 15 high.
// - access-select one uses pointer plus offset.
// - access-select zero uses map, ignores pointer.
// - access-map access needs one instruction cycle.
// - extended isa changes access-bank mapping.
// - operand read in Q2, write in Q4.
// - special regs F80h-FFFh, general from 000h.
// - general storage never cleared by reset.
`ifndef BDM_REGS_VH
`define BDM_REGS_VH

`define BDM_ADDR_W 12
`define BDM_DATA_W 8
`define BDM_BANK_W 4
`define BDM_OFF_W 8
`define BDM_NUM_BANKS 16
`define BDM_IMPL_BANKS 16'hffff
`define BDM_GPR_BYTES 3968
`define BDM_GPR_BASE 12'h000
`define BDM_SFR_BASE 12'hf80
`define BDM_BANK_PTR_ADDR 12'hfe0
`define BDM_BANK_PTR_RST 4'h0
`define BDM_ACC_SPLIT 8'h80
`define BDM_ACC_LO_BANK 4'h0
`define BDM_ACC_HI_BANK 4'hf
`define BDM_EXT_LIMIT 8'h60
`define BDM_Q1 4'b0001
`define BDM_Q2 4'b0010
`define BDM_Q3 4'b0100
`define BDM_Q4 4'b1000

`endif

// ===== src/bdm_addr_gen.v
// Purpose: resolve one data address from an instruction's fields
// Assumes: fields held stable for the whole instruction cycle
// Notes: purely combinational, used for source and destination
`timescale 1ns/1ns
`include "bdm_regs.vh"

module bdm_addr_gen (
    input wire i_full_move,
    input wire [`BDM_ADDR_W-1:0] i_full_addr,
    input wire [`BDM_OFF_W-1:0] i_offset,
    input wire i_access_sel,
    input wire [`BDM_BANK_W-1:0] i_bank_pointer_bits,
    input wire i_extended_isa_enable,
    input wire [`BDM_ADDR_W-1:0] i_index_base,
    output reg [`BDM_ADDR_W-1:0] o_addr,
    output reg o_indexed
);

    // no clock here, so every source costs no extra cycle
    always @* begin
        o_indexed = 1'b0;
        if (i_full_move) begin
            o_addr = i_full_addr;
        end else if (i_access_sel) begin
            o_addr = {i_bank_pointer_bits, i_offset};
        end else if (i_extended_isa_enable && (i_offset < `BDM_EXT_LIMIT)) begin
            // low window becomes relative to the index base
            o_addr = i_index_base + {4'h0, i_offset};
            o_indexed = 1'b1;
        end else if (i_offset < `BDM_ACC_SPLIT) begin
            o_addr = {`BDM_ACC_LO_BANK, i_offset};
        end else begin
            o_addr = {`BDM_ACC_HI_BANK, i_offset};
        end
    end

endmodule

// ===== src/bdm_gpr_ram.v
// Purpose: general-purpose byte storage in flip-flops
// Assumes: one write port, one combinational read port
// Notes: no reset on the array, contents survive every reset
`timescale 1ns/1ns
`include "bdm_regs.vh"

module bdm_gpr_ram #(
    parameter DEPTH = `BDM_GPR_BYTES
) (
    input wire i_clk,
    input wire i_ce,
    input wire i_we,
    input wire [`BDM_ADDR_W-1:0] i_waddr,
    input wire [`BDM_DATA_W-1:0] i_wdata,
    input wire [`BDM_ADDR_W-1:0] i_raddr,
    output wire [`BDM_DATA_W-1:0] o_rdata
);

    // byte-wide cells behind the 12-bit address
    reg [`BDM_DATA_W-1:0] mem [0:DEPTH-1];

    // deliberately outside the reset
    always @(posedge i_clk) begin
        if (i_ce && i_we && (i_waddr < DEPTH)) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // beyond the array nothing answers
    assign o_rdata = (i_raddr < DEPTH) ? mem[i_raddr] : 8'h00;

endmodule

// ===== src/bdm_data_mem.v
// Purpose: data memory address generation and access for the core
// Assumes: core drives instruction fields in Q1, write data by Q3
// Notes: special registers other than the bank pointer live outside
`timescale 1ns/1ns
`include "bdm_regs.vh"

module bdm_data_mem #(
    parameter IMPL_BANKS = `BDM_IMPL_BANKS,
    parameter GPR_BYTES = `BDM_GPR_BYTES
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_instr_valid,
    input wire i_full_move,
    input wire [`BDM_ADDR_W-1:0] i_full_src,
    input wire [`BDM_ADDR_W-1:0] i_full_dst,
    input wire [`BDM_OFF_W-1:0] i_offset,
    input wire i_access_sel,
    input wire i_rd_en,
    input wire i_wr_en,
    input wire [`BDM_DATA_W-1:0] i_wdata,
    input wire i_load_bank_literal,
    input wire [`BDM_DATA_W-1:0] i_literal,
    input wire i_extended_isa_enable,
    input wire [`BDM_ADDR_W-1:0] i_index_base,
    input wire i_sfr_hit,
    input wire [`BDM_DATA_W-1:0] i_sfr_rdata,
    output wire [3:0] o_phase,
    output reg [`BDM_DATA_W-1:0] o_rdata,
    output reg o_rd_unimpl,
    output reg o_wr_discard,
    output reg o_flags_update,
    output reg o_indexed,
    output wire [`BDM_DATA_W-1:0] o_bank_pointer,
    output wire o_sfr_rd,
    output wire o_sfr_wr,
    output wire [`BDM_ADDR_W-1:0] o_sfr_addr,
    output reg [`BDM_DATA_W-1:0] o_sfr_wdata
);

    // ******************************************************
    // address decode helpers
    // ******************************************************
    function is_sfr;
        input [`BDM_ADDR_W-1:0] a;
        begin
            is_sfr = (a >= `BDM_SFR_BASE);
        end
    endfunction

    function is_bank_ptr;
        input [`BDM_ADDR_W-1:0] a;
        begin
            is_bank_ptr = (a == `BDM_BANK_PTR_ADDR);
        end
    endfunction

    function bank_present;
        input [`BDM_ADDR_W-1:0] a;
        reg [15:0] banks;
        begin
            banks = IMPL_BANKS;
            bank_present = banks[a[`BDM_ADDR_W-1:`BDM_OFF_W]];
        end
    endfunction

    function is_gpr;
        input [`BDM_ADDR_W-1:0] a;
        begin
            is_gpr = (a < GPR_BYTES);
        end
    endfunction

    // ******************************************************
    // quarter-cycle sequencer
    // ******************************************************
    localparam Q1 = `BDM_Q1;
    localparam Q2 = `BDM_Q2;
    localparam Q3 = `BDM_Q3;
    localparam Q4 = `BDM_Q4;

    reg [3:0] q_reg;
    reg [3:0] q_next;

    always @* begin
        case (q_reg)
            Q1: q_next = Q2;
            Q2: q_next = Q3;
            Q3: q_next = Q4;
            Q4: q_next = Q1;
            default: q_next = Q1;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            q_reg <= Q1;
        end else if (i_ce) begin
            q_reg <= q_next;
        end
    end

    assign o_phase = q_reg;

    // ******************************************************
    // instruction fields, latched at the end of Q1
    // ******************************************************
    reg act_reg;
    reg full_reg;
    reg [`BDM_ADDR_W-1:0] src_reg;
    reg [`BDM_ADDR_W-1:0] dst_reg;
    reg [`BDM_OFF_W-1:0] off_reg;
    reg asel_reg;
    reg rd_reg;
    reg wr_reg;
    reg lbl_reg;
    reg [`BDM_BANK_W-1:0] lit_reg;
    reg ext_reg;
    reg [`BDM_ADDR_W-1:0] base_reg;

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            act_reg <= 1'b0;
            full_reg <= 1'b0;
            src_reg <= 12'h000;
            dst_reg <= 12'h000;
            off_reg <= 8'h00;
            asel_reg <= 1'b0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            lbl_reg <= 1'b0;
            lit_reg <= 4'h0;
            ext_reg <= 1'b0;
            base_reg <= 12'h000;
        end else if (i_ce && (q_reg == Q1)) begin
            act_reg <= i_instr_valid;
            full_reg <= i_full_move;
            src_reg <= i_full_src;
            dst_reg <= i_full_dst;
            off_reg <= i_offset;
            asel_reg <= i_access_sel;
            // a move always reads its source and writes its target
            rd_reg <= i_instr_valid && (i_rd_en || i_full_move);
            wr_reg <= i_instr_valid && (i_wr_en || i_full_move);
            lbl_reg <= i_instr_valid && i_load_bank_literal;
            lit_reg <= i_literal[`BDM_BANK_W-1:0];
            ext_reg <= i_extended_isa_enable;
            base_reg <= i_index_base;
        end
    end

    // ******************************************************
    // bank pointer
    // ******************************************************
    reg [`BDM_BANK_W-1:0] bank_pointer_bits_reg;

    // upper nibble is not stored at all
    assign o_bank_pointer = {4'h0, bank_pointer_bits_reg};

    // ******************************************************
    // address resolution, source and destination
    // ******************************************************
    wire [`BDM_ADDR_W-1:0] rd_addr;
    wire [`BDM_ADDR_W-1:0] wr_addr;
    wire rd_indexed;
    wire wr_indexed;

    bdm_addr_gen u_rd_addr (
        .i_full_move(full_reg),
        .i_full_addr(src_reg),
        .i_offset(off_reg),
        .i_access_sel(asel_reg),
        .i_bank_pointer_bits(bank_pointer_bits_reg),
        .i_extended_isa_enable(ext_reg),
        .i_index_base(base_reg),
        .o_addr(rd_addr),
        .o_indexed(rd_indexed)
    );

    // a move's destination is its own full address, never banked
    bdm_addr_gen u_wr_addr (
        .i_full_move(full_reg),
        .i_full_addr(dst_reg),
        .i_offset(off_reg),
        .i_access_sel(asel_reg),
        .i_bank_pointer_bits(bank_pointer_bits_reg),
        .i_extended_isa_enable(ext_reg),
        .i_index_base(base_reg),
        .o_addr(wr_addr),
        .o_indexed(wr_indexed)
    );

    // ******************************************************
    // access strobes
    // ******************************************************
    wire rd_phase;
    wire wr_phase;
    wire rd_ok;
    wire wr_ok;
    wire [`BDM_DATA_W-1:0] ram_rdata;
    reg [`BDM_DATA_W-1:0] wdata_reg;
    reg [`BDM_DATA_W-1:0] rd_value;

    assign rd_phase = i_ce && act_reg && rd_reg && (q_reg == Q2);
    assign wr_phase = i_ce && act_reg && wr_reg && (q_reg == Q4);
    assign rd_ok = bank_present(rd_addr);
    assign wr_ok = bank_present(wr_addr);

    // external registers only, the bank pointer is answered here
    assign o_sfr_rd = rd_phase && rd_ok && is_sfr(rd_addr) && !is_bank_ptr(rd_addr);
    assign o_sfr_wr = wr_phase && wr_ok && is_sfr(wr_addr) && !is_bank_ptr(wr_addr);
    assign o_sfr_addr = (q_reg == Q4) ? wr_addr : rd_addr;

    bdm_gpr_ram #(
        .DEPTH(GPR_BYTES)
    ) u_gpr (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_we(wr_phase && wr_ok && is_gpr(wr_addr)),
        .i_waddr(wr_addr),
        .i_wdata(wdata_reg),
        .i_raddr(rd_addr),
        .o_rdata(ram_rdata)
    );

    // read mux, zero wherever nothing stands behind the address
    always @* begin
        rd_value = 8'h00;
        if (rd_ok) begin
            if (is_bank_ptr(rd_addr)) begin
                rd_value = o_bank_pointer;
            end else if (is_sfr(rd_addr)) begin
                if (i_sfr_hit) begin
                    rd_value = i_sfr_rdata;
                end
            end else if (is_gpr(rd_addr)) begin
                rd_value = ram_rdata;
            end
        end
    end

    // ******************************************************
    // operand capture, write data and bank pointer updates
    // ******************************************************
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
            o_rd_unimpl <= 1'b0;
            o_indexed <= 1'b0;
        end else if (rd_phase) begin
            o_rdata <= rd_value;
            o_rd_unimpl <= !rd_ok || (is_sfr(rd_addr) && !is_bank_ptr(rd_addr) && !i_sfr_hit);
            o_indexed <= rd_indexed || wr_indexed;
        end
    end

    // alu result is sampled at the end of Q3, a move copies its operand
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            wdata_reg <= 8'h00;
            o_sfr_wdata <= 8'h00;
        end else if (i_ce && (q_reg == Q3)) begin
            wdata_reg <= full_reg ? o_rdata : i_wdata;
            o_sfr_wdata <= full_reg ? o_rdata : i_wdata;
        end
    end

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            bank_pointer_bits_reg <= `BDM_BANK_PTR_RST;
        end else if (i_ce && (q_reg == Q4) && act_reg) begin
            if (lbl_reg) begin
                bank_pointer_bits_reg <= lit_reg;
            end else if (wr_phase && wr_ok && is_bank_ptr(wr_addr)) begin
                // upper written bits are simply dropped
                bank_pointer_bits_reg <= wdata_reg[`BDM_BANK_W-1:0];
            end
        end
    end

    // ******************************************************
    // completion reporting
    // ******************************************************
    // flags pulse even when the write was dropped, the alu must not care
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_wr_discard <= 1'b0;
            o_flags_update <= 1'b0;
        end else if (i_ce) begin
            o_wr_discard <= wr_phase && !wr_ok;
            o_flags_update <= i_ce && act_reg && (q_reg == Q4) && (rd_reg || wr_reg);
        end
    end

endmodule

// ===== verification/bdm_data_mem_asserts.sv
// Purpose: port-level timing checks for bdm_data_mem
// Assumes: one core clock, synchronous active-low reset
// Notes: bound into the design from the bench top file
`timescale 1ns/1ns
`include "bdm_regs.vh"
module bdm_data_mem_asserts (
    input wire i_clk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_instr_valid,
    input wire i_full_move,
    input wire i_rd_en,
    input wire i_wr_en,
    input wire i_load_bank_literal,
    input wire [`BDM_DATA_W-1:0] i_literal,
    input wire [3:0] o_phase,
    input wire [`BDM_DATA_W-1:0] o_rdata,
    input wire o_rd_unimpl,
    input wire o_wr_discard,
    input wire o_flags_update,
    input wire [`BDM_DATA_W-1:0] o_bank_pointer,
    input wire o_sfr_rd,
    input wire o_sfr_wr,
    input wire [`BDM_ADDR_W-1:0] o_sfr_addr
);
    // ****
    // fields as latched at the Q1 edge
    // ****
    reg ld_reg;
    reg acc_reg;
    reg [3:0] lit_reg;
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            ld_reg <= 1'b0;
            acc_reg <= 1'b0;
            lit_reg <= 4'h0;
        end else if (i_ce && o_phase == `BDM_Q1) begin
            ld_reg <= i_instr_valid & i_load_bank_literal;
            acc_reg <= i_instr_valid & (i_rd_en | i_wr_en | i_full_move);
            lit_reg <= i_literal[3:0];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_q4;
        o_phase == `BDM_Q4 && i_ce;
    endsequence
    sequence s_mid;
        (o_phase == `BDM_Q2 && i_ce) ##1 (o_phase == `BDM_Q3 && i_ce);
    endsequence
    AST_PHASE_STEP: assert property (s_mid |=> o_phase == `BDM_Q4)
        else $error("phase skipped Q4");
    AST_PHASE_WRAP: assert property (s_q4 |=> o_phase == `BDM_Q1)
        else $error("cycle longer than four phases");
    AST_SFR_RD_Q2: assert property (o_sfr_rd |-> o_phase == `BDM_Q2 && i_ce)
        else $error("special read outside Q2");
    AST_SFR_WR_Q4: assert property (o_sfr_wr |-> o_phase == `BDM_Q4 && o_sfr_addr >= 12'hf80)
        else $error("special write outside Q4 or range");
    AST_PTR_UPPER: assert property (o_bank_pointer[7:4] == 4'h0)
        else $error("pointer upper bits set");
    AST_PTR_LOAD: assert property (s_q4 ##0 ld_reg |=> o_bank_pointer == {4'h0, lit_reg})
        else $error("pointer not loaded from literal");
    AST_FLAGS_EVERY: assert property (s_q4 ##0 acc_reg |=> o_flags_update)
        else $error("flag update missing");
    AST_FLAGS_ONLY: assert property (o_flags_update |-> $past(o_phase) == `BDM_Q4 && $past(acc_reg))
        else $error("flag update without access");
    AST_DISCARD_PAIR: assert property (o_wr_discard |-> o_flags_update)
        else $error("discard without flag update");
    AST_UNIMPL_ZERO: assert property (o_rd_unimpl |-> o_rdata == 8'h00)
        else $error("empty read not zero");
    AST_RDATA_HOLD: assert property (o_phase != `BDM_Q2 |=> $stable(o_rdata))
        else $error("operand changed outside Q2 edge");
endmodule

// ===== verification/bdm_sfr_model.sv
// Purpose: special registers answering outside the block
// Assumes: only F80h-F8Fh are present, writes are ignored
// Notes: combinational answer during the read strobe
`timescale 1ns/1ns
`include "bdm_regs.vh"
module bdm_sfr_model (
    input wire i_rd,
    input wire [`BDM_ADDR_W-1:0] i_addr,
    output wire o_hit,
    output wire [`BDM_DATA_W-1:0] o_data
);
    assign o_hit = i_rd & (i_addr[11:4] == 8'hf8);
    // released bus shows inverted data so a stale sample cannot match
    assign o_data = o_hit ? i_addr[7:0] ^ 8'h5a : ~(i_addr[7:0] ^ 8'h5a);
endmodule

// ===== verification/tb.sv
// Purpose: self-checking bench for bdm_data_mem
// Assumes: bank 14 left out to reach the absent-bank paths
// Notes: op() plays the core, bdm_sfr_model the special registers
`timescale 1ns/1ns
`include "bdm_regs.vh"
module tb;
    reg i_clk = 0, i_resetn = 0, vld = 0, fm = 0, sel = 0, rd = 0, wr = 0, ld = 0, ext = 0;
    reg [11:0] src = 0, dst = 0, ib = 0, s2;
    reg [7:0] off = 0, wd = 0, lit = 0, o, t;
    wire hit, unimpl, disc, flg, idx, srd, swr;
    wire [7:0] swd;
    logic [19:0] qs[$];
    logic [19:0] es;
    wire [3:0] phase;
    wire [7:0] rdata, bp, sdata;
    wire [11:0] saddr;
    reg [7:0] mem [0:4095];
    reg [3:0] bpm = 0;
    reg [9:0] lr = 0;
    logic [14:0] q[$];
    logic [14:0] e;
    integer failures = 0, cmp_count = 0, i, k;
    reg [31:0] lf = 32'h08b6;
    always #10 i_clk = ~i_clk;
    bdm_data_mem #(.IMPL_BANKS(16'hbfff)) i_bdm_data_mem (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1),
        .i_instr_valid(vld), .i_full_move(fm), .i_full_src(src), .i_full_dst(dst), .i_offset(off),
        .i_access_sel(sel), .i_rd_en(rd), .i_wr_en(wr), .i_wdata(wd), .i_load_bank_literal(ld),
        .i_literal(lit), .i_extended_isa_enable(ext), .i_index_base(ib), .i_sfr_hit(hit),
        .i_sfr_rdata(sdata), .o_phase(phase), .o_rdata(rdata), .o_rd_unimpl(unimpl), .o_wr_discard(disc),
        .o_flags_update(flg), .o_indexed(idx), .o_bank_pointer(bp), .o_sfr_rd(srd), .o_sfr_wr(swr),
        .o_sfr_addr(saddr), .o_sfr_wdata(swd));
    bdm_sfr_model i_bdm_sfr_model (.i_rd(srd), .i_addr(saddr), .o_hit(hit), .o_data(sdata));
    function [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        rnd = lf[7:0];
    endfunction
    function [11:0] ea(input [7:0] a, input s);
        if (s) ea = {bpm, a};
        else if (ext && a < `BDM_EXT_LIMIT) ea = ib + a;
        else ea = {a[7] ? `BDM_ACC_HI_BANK : `BDM_ACC_LO_BANK, a};
    endfunction
    task chk(input [63:0] nm, input [7:0] x, g);
        cmp_count = cmp_count + 1;
        if (g !== x) begin
            failures = failures + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, x, g);
        end
    endtask
    task end_sim;
        $display("counts: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****
    // one instruction, expectation noted before it runs
    // ****
    task op(input f, input [11:0] s, d, input [7:0] a, input sl, r, w, l, input [7:0] v, dt);
        reg [11:0] ra, wa;
        reg [7:0] rv;
        reg u;
        integer n;
        begin
            n = 0;
            while (phase !== `BDM_Q1) begin
                @(negedge i_clk);
                n = n + 1;
                if (n > 8) begin
                    failures = failures + 1;
                    end_sim;
                end
            end
            {vld, fm, src, dst, off, sel, rd, wr, ld, lit, wd} = {1'b1, f, s, d, a, sl, r, w, l, v, dt};
            ra = f ? s : ea(a, sl);
            wa = f ? d : ra;
            u = ra[11:8] == 4'he || (ra >= 12'hf80 && ra != 12'hfe0 && ra[11:4] != 8'hf8);
            rv = u ? 8'h00 : ra == 12'hfe0 ? {4'h0, bpm} : ra >= 12'hf80 ? ra[7:0] ^ 8'h5a : mem[ra];
            if (r) lr = {rv, u, !f && !sl && ext && a < `BDM_EXT_LIMIT};
            if (f) dt = rv;
            if (w && wa < 12'hf80 && wa[11:8] != 4'he) mem[wa] = dt;
            if (w && wa == 12'hfe0) bpm = dt[3:0];
            if (w && wa >= 12'hf80 && wa != 12'hfe0) qs.push_back({dt, wa});
            if (l) bpm = v[3:0];
            if (r || w) q.push_back({lr, bpm, w && wa[11:8] == 4'he});
            repeat (4) @(negedge i_clk);
        end
    endtask
    always @(negedge i_clk) begin
        if (flg === 1'b1) begin
            if (q.size() == 0) chk("queue", 8'h01, 8'h00);
            else begin
                e = q.pop_front();
                chk("rdata", e[14:7], rdata);
                chk("unimpl", e[6], unimpl);
                chk("indexed", e[5], idx);
                chk("pointer", e[4:1], bp);
                chk("discard", e[0], disc);
            end
        end
        if (swr === 1'b1) begin
            if (qs.size() == 0) chk("sfrq", 8'h01, 8'h00);
            else begin
                es = qs.pop_front();
                chk("sfraddr", es[7:0], saddr[7:0]);
                chk("sfrwdata", es[19:12], swd);
            end
        end
    end
    initial begin
        repeat (10) @(negedge i_clk);
        i_resetn = 1;
        for (i = 0; i < 128; i = i + 1) op(0, 0, 0, i[7:0], 0, 0, 1, 0, 0, rnd());
        $display("test fill done");
        for (k = 0; k < 16; k = k + 1) begin
            t = rnd();
            op(0, 0, 0, 0, 0, 0, 0, 1, {t[7:4], k[3:0]}, 0);
            o = rnd();
            op(0, 0, 0, o, 1, 0, 1, 0, 0, rnd());
            op(0, 0, 0, o, 1, 1, 0, 0, 0, 0);
            op(0, 0, 0, rnd(), 0, 1, 0, 0, 0, 0);
            t = rnd();
            s2 = {k[3:0], rnd()};
            op(1, {5'h00, t[6:0]}, s2, 0, 1, 1, 1, 0, 0, 0);
            op(1, s2, 0, 0, 0, 1, 0, 0, 0, 0);
        end
        $display("test banks done");
        op(0, 0, 0, 8'he0, 0, 1, 1, 1, 8'h3c, 8'h05);
        op(0, 0, 0, 8'he0, 0, 0, 1, 0, 0, 8'hff);
        op(0, 0, 0, 8'he0, 0, 1, 0, 0, 0, 0);
        $display("test pointer done");
        t = rnd();
        ext = 1;
        ib = {7'h00, t[4:0]};
        for (i = 0; i < 4; i = i + 1) op(0, 0, 0, i == 3 ? rnd() : 8'h5f + i[7:0], 0, 1, 0, 0, 0, 0);
        ext = 0;
        $display("test extended done");
        i_resetn = 0;
        vld = 0;
        repeat (2) @(negedge i_clk);
        i_resetn = 1;
        bpm = 0;
        op(0, 0, 0, 8'h10, 1, 1, 0, 0, 0, 0);
        repeat (2) @(negedge i_clk);
        $display("test reset done");
        if (q.size() != 0 || qs.size() != 0) failures = failures + 1;
        end_sim;
    end
endmodule
bind bdm_data_mem bdm_data_mem_asserts i_bdm_data_mem_asserts (.*);
